// File: ptc_pkg.sv
package ptc_pkg;

   // Clock rate and documented debounce times
   localparam int CLK_MHZ           = 50;
   localparam int SD_DEBOUNCE_US    = 8000;   // 8.0 ms thermal shutdown filter
   localparam int WARN_DEBOUNCE_US  = 3900;   // 3.9 ms thermal warning filter
   localparam int SD_DEBOUNCE_CYC   = SD_DEBOUNCE_US * CLK_MHZ;
   localparam int WARN_DEBOUNCE_CYC = WARN_DEBOUNCE_US * CLK_MHZ;

   // Register offsets
   localparam logic [7:0] ADDR_INT_STATUS = 8'h05;
   localparam logic [7:0] ADDR_INT_MASK   = 8'h06;
   localparam logic [7:0] ADDR_INT_SENSE  = 8'h07;
   localparam logic [7:0] ADDR_COIN_CTL   = 8'h1a;

   // Reset values
   localparam logic [7:0] COIN_CTL_RST   = 8'h00;
   localparam logic [7:0] INT_STATUS_RST = 8'h00;
   localparam logic [7:0] INT_MASK_RST   = 8'h3f;

   // Field layout
   localparam int         COIN_EN_BIT    = 3;
   localparam int         COIN_VSEL_LSB  = 0;
   localparam int         COIN_VSEL_W    = 3;
   localparam logic [7:0] COIN_CTL_WMASK = 8'h0f;
   localparam logic [7:0] INT_MASK_WMASK = 8'h3f;
   localparam int         THERM_LSB      = 2;
   localparam int         N_WARN         = 4;
   localparam logic [7:0] THERM_FIELD    = 8'h3c;

   // Power states, one-hot
   typedef enum logic [2:0] {
      PTC_OFF  = 3'b001,
      PTC_ON   = 3'b010,
      PTC_COIN = 3'b100
   } ptc_state_t;

   // Analog comparator bundle
   typedef struct packed {
      logic                uv_below;
      logic                pwr_on;
      logic                sd_hot;
      logic                sd_release;
      logic                coin_exhausted;
      logic [N_WARN-1:0]   warn;
   } ptc_cmp_t;

   // Byte register access from the serial front end
   typedef struct packed {
      logic       req;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ptc_reg_req_t;

   typedef struct packed {
      logic       ack;
      logic       nak;
      logic [7:0] rdata;
   } ptc_reg_rsp_t;

endpackage : ptc_pkg

// File: ptc_sync.sv
`timescale 1ns/1ps
module ptc_sync import ptc_pkg::*; #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // Two stages; first stage feeds only the second
   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else if (ce) begin
         meta_reg <= meta_next;
         q_reg    <= q_next;
      end
   end

   assign q = q_reg;

endmodule : ptc_sync

// File: ptc_debounce.sv
`timescale 1ns/1ps
module ptc_debounce import ptc_pkg::*; #(
   parameter int N = 16
) (
   input  wire logic clk_sys,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic d,
   output logic      q
);

   localparam int             CW   = $clog2(N + 1);
   localparam logic [CW-1:0]  LAST = CW'(N - 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          q_reg;
   logic          q_next;

   // Level must disagree for N cycles in a row; any agreement restarts
   always_comb begin
      cnt_next = '0;
      q_next   = q_reg;
      if (d != q_reg) begin
         if (cnt_reg == LAST) begin
            q_next = d;
         end else begin
            cnt_next = cnt_reg + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_reg <= '0;
         q_reg   <= 1'b0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
         q_reg   <= q_next;
      end
   end

   assign q = q_reg;

endmodule : ptc_debounce

// File: ptc_ctrl.sv
// Contract
// - charger runs only while enable bit 3 of charger control is set
// - bits 2:0 select charger voltage, 2.50 V at 000 up to 3.30 V at 111
// - enabled charger uses fixed high current in ON; never charges in OFF
// - charging stops whenever main input is below undervoltage threshold
// - charger control resets to 0x00; upper four bits unused
// - four thermal warnings raise interrupts on each crossing, both directions
// - sense register shows four live thermal comparator bits
// - thermal shutdown taken only after over-temperature holds 8.0 ms
// - after thermal shutdown stay OFF, ignore turn-on until temperature released
// - exactly three power states: ON, OFF, coin-cell
// - OFF to ON only with power-on pin high and input above undervoltage
// - ON or OFF go to coin-cell when input falls below undervoltage
// - ON to OFF when power-on pin low or thermal shutdown
// - coin-cell ignores turn-on; exits only to OFF when input recovers
// - host reset released in ON, pulled high externally
// - host reset driven low in OFF and coin-cell
// - register access refused in coin-cell state
// - interrupt output asserted only in ON
// - in OFF only core digital and backup supplies stay powered
// - exhausted coin cell fully resets every register to default
// - status bits latch until written with 1; output low while unmasked set
// - all interrupt mask bits reset to set
`timescale 1ns/1ps
module ptc_ctrl import ptc_pkg::*; #(
   parameter int SD_DB_CYCLES   = SD_DEBOUNCE_CYC,
   parameter int WARN_DB_CYCLES = WARN_DEBOUNCE_CYC
) (
   input  wire logic                   clk_sys,
   input  wire logic                   srst,
   input  wire logic                   ce,
   input  wire ptc_cmp_t               cmp_in,
   input  wire ptc_reg_req_t           reg_req,
   output ptc_reg_rsp_t                reg_rsp,
   output logic                        host_reset_out,
   output logic                        host_reset_out_oe,
   output logic                        interrupt_out_n,
   output logic                        charger_on,
   output logic                        charger_fixed_current,
   output logic [COIN_VSEL_W-1:0]      charger_voltage_select,
   output logic                        core_digital_supply_en,
   output logic                        backup_domain_supply_en,
   output logic                        other_regulators_en,
   output ptc_state_t                  power_state
);

   ptc_cmp_t          cmp_s;
   logic              sd_db;
   logic [N_WARN-1:0] warn_db;

   // Inputs are asynchronous analog comparators
   ptc_sync #(.W($bits(ptc_cmp_t))) u_sync (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ce      (ce),
      .d       (cmp_in),
      .q       (cmp_s)
   );

   // Noise must not power the part down
   ptc_debounce #(.N(SD_DB_CYCLES)) u_sd_db (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ce      (ce),
      .d       (cmp_s.sd_hot),
      .q       (sd_db)
   );

   // One filter per warning threshold
   for (genvar i = 0; i < N_WARN; i++) begin : g_warn
      ptc_debounce #(.N(WARN_DB_CYCLES)) u_warn_db (
         .clk_sys (clk_sys),
         .srst    (srst),
         .ce      (ce),
         .d       (cmp_s.warn[i]),
         .q       (warn_db[i])
      );
   end

   // ---------------- Power state machine ----------------
   ptc_state_t state_reg;
   ptc_state_t state_next;
   logic       lock_reg;
   logic       lock_next;

   // Thermal lock: set wins over release so a trip is never lost
   always_comb begin
      lock_next = lock_reg;
      if (sd_db) begin
         lock_next = 1'b1;
      end else if (cmp_s.sd_release) begin
         lock_next = 1'b0;
      end
   end

   // Undervoltage outranks every other exit
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PTC_OFF: begin
            if (cmp_s.uv_below) begin
               state_next = PTC_COIN;
            end else if (cmp_s.pwr_on && !lock_reg && !sd_db) begin
               state_next = PTC_ON;
            end
         end
         PTC_ON: begin
            if (cmp_s.uv_below) begin
               state_next = PTC_COIN;
            end else if (!cmp_s.pwr_on || sd_db) begin
               state_next = PTC_OFF;
            end
         end
         PTC_COIN: begin
            if (!cmp_s.uv_below) begin
               state_next = PTC_OFF;
            end
         end
         default: state_next = PTC_OFF;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= PTC_OFF;
         lock_reg  <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         lock_reg  <= lock_next;
      end
   end

   // ---------------- Registers ----------------
   logic [7:0]        ctl_reg;
   logic [7:0]        ctl_next;
   logic [7:0]        stat_reg;
   logic [7:0]        stat_next;
   logic [7:0]        mask_reg;
   logic [7:0]        mask_next;
   logic [N_WARN-1:0] warn_prev_reg;
   logic [N_WARN-1:0] warn_prev_next;
   ptc_reg_rsp_t      rsp_reg;
   ptc_reg_rsp_t      rsp_next;
   logic [7:0]        therm_evt;
   logic              acc_ok;

   // Coin state has no serial interface power
   assign acc_ok = reg_req.req && (state_reg != PTC_COIN);

   // Any crossing of a filtered threshold is an event
   assign therm_evt = 8'((warn_db ^ warn_prev_reg)) << THERM_LSB;

   // Register access, write-one-to-clear and event latching
   always_comb begin
      ctl_next       = ctl_reg;
      mask_next      = mask_reg;
      warn_prev_next = warn_db;
      rsp_next       = '0;
      stat_next      = stat_reg;
      if (reg_req.req && !acc_ok) begin
         rsp_next.nak = 1'b1;
      end
      if (acc_ok) begin
         rsp_next.ack = 1'b1;
         if (reg_req.wr) begin
            unique case (reg_req.addr)
               ADDR_COIN_CTL: ctl_next = (ctl_reg & ~COIN_CTL_WMASK)
                                         | (reg_req.wdata & COIN_CTL_WMASK);
               ADDR_INT_MASK: mask_next = reg_req.wdata & INT_MASK_WMASK;
               ADDR_INT_STATUS: stat_next = stat_reg & ~(reg_req.wdata & THERM_FIELD);
               default: ;
            endcase
         end else begin
            unique case (reg_req.addr)
               ADDR_COIN_CTL:   rsp_next.rdata = ctl_reg;
               ADDR_INT_MASK:   rsp_next.rdata = mask_reg;
               ADDR_INT_STATUS: rsp_next.rdata = stat_reg;
               ADDR_INT_SENSE:  rsp_next.rdata = 8'(cmp_s.warn) << THERM_LSB;
               default:         rsp_next.rdata = 8'h00;
            endcase
         end
      end
      // New event wins over a clear in the same cycle
      stat_next = stat_next | therm_evt;
      // Dead coin cell returns every bit to default
      if (cmp_s.coin_exhausted) begin
         ctl_next  = COIN_CTL_RST;
         stat_next = INT_STATUS_RST;
         mask_next = INT_MASK_RST;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctl_reg       <= COIN_CTL_RST;
         stat_reg      <= INT_STATUS_RST;
         mask_reg      <= INT_MASK_RST;
         warn_prev_reg <= '0;
         rsp_reg       <= '0;
      end else if (ce) begin
         ctl_reg       <= ctl_next;
         stat_reg      <= stat_next;
         mask_reg      <= mask_next;
         warn_prev_reg <= warn_prev_next;
         rsp_reg       <= rsp_next;
      end
   end

   // ---------------- Outputs ----------------
   logic                   chg_next;
   logic                   int_n_next;
   logic                   out_chg_reg;
   logic                   out_int_n_reg;
   logic                   out_rst_oe_reg;
   logic                   out_oth_reg;
   logic [COIN_VSEL_W-1:0] out_vsel_reg;

   // Outputs follow next state so they line up with state_reg
   always_comb begin
      chg_next   = ctl_next[COIN_EN_BIT]
                   && (state_next == PTC_ON)
                   && !cmp_s.uv_below;
      int_n_next = !((state_next == PTC_ON)
                     && |(stat_next & ~mask_next & THERM_FIELD));
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         out_chg_reg    <= 1'b0;
         out_int_n_reg  <= 1'b1;
         out_rst_oe_reg <= 1'b1;
         out_oth_reg    <= 1'b0;
         out_vsel_reg   <= COIN_CTL_RST[COIN_VSEL_LSB +: COIN_VSEL_W];
      end else if (ce) begin
         out_chg_reg    <= chg_next;
         out_int_n_reg  <= int_n_next;
         out_rst_oe_reg <= (state_next != PTC_ON);
         out_oth_reg    <= (state_next == PTC_ON);
         out_vsel_reg   <= ctl_next[COIN_VSEL_LSB +: COIN_VSEL_W];
      end
   end

   // Reset pin is open drain: only ever pulls low
   assign host_reset_out          = 1'b0;
   assign host_reset_out_oe       = out_rst_oe_reg;
   assign interrupt_out_n         = out_int_n_reg;
   assign charger_on              = out_chg_reg;
   assign charger_fixed_current   = out_chg_reg;  // Single level, no trickle mode
   assign charger_voltage_select  = out_vsel_reg;
   assign core_digital_supply_en  = 1'b1;         // Always on, also in OFF
   assign backup_domain_supply_en = 1'b1;
   assign other_regulators_en     = out_oth_reg;
   assign reg_rsp                 = rsp_reg;
   assign power_state             = state_reg;

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_charger_enable: assert property (charger_on |-> ctl_reg[COIN_EN_BIT])
      else $error("charger on while enable bit clear");
   a_charger_state: assert property (state_reg != PTC_ON |-> !charger_on)
      else $error("charger on outside ON");
   a_charger_uv: assert property (ce && cmp_s.uv_below |=> !charger_on)
      else $error("charger on during undervoltage");
   a_reset_low: assert property (state_reg != PTC_ON |-> host_reset_out_oe)
      else $error("host reset released outside ON");
   a_reset_release: assert property (state_reg == PTC_ON |-> !host_reset_out_oe)
      else $error("host reset held in ON");
   a_int_only_on: assert property (!interrupt_out_n |-> state_reg == PTC_ON)
      else $error("interrupt asserted outside ON");
   a_int_pending: assert property ((state_reg == PTC_ON)
         && |(stat_reg & ~mask_reg) |-> !interrupt_out_n)
      else $error("unmasked status without interrupt");
   a_coin_refuse: assert property (ce && reg_req.req && state_reg == PTC_COIN
         |=> reg_rsp.nak && !reg_rsp.ack)
      else $error("register access accepted in coin state");
   a_coin_exit: assert property (ce && state_reg == PTC_COIN && !cmp_s.uv_below
         |=> state_reg == PTC_OFF)
      else $error("coin state exit wrong");
   a_lock_blocks: assert property (ce && lock_reg && state_reg == PTC_OFF
         |=> state_reg != PTC_ON)
      else $error("turn-on accepted under thermal lock");
   a_off_to_on: assert property (ce && state_reg == PTC_OFF && cmp_s.pwr_on
         && !cmp_s.uv_below && !lock_reg && !sd_db |=> state_reg == PTC_ON)
      else $error("valid turn-on not taken");
   a_sd_turn_off: assert property (ce && state_reg == PTC_ON && sd_db
         |=> state_reg != PTC_ON)
      else $error("thermal shutdown ignored");
   // Each crossing lands in its own bit; a dead coin cell wipes status instead
   a_evt_latch: assert property (ce && |therm_evt && !cmp_s.coin_exhausted
         |=> (stat_reg & $past(therm_evt)) == $past(therm_evt))
      else $error("thermal crossing not latched");
   a_coin_reset: assert property (ce && cmp_s.coin_exhausted
         |=> ctl_reg == COIN_CTL_RST && mask_reg == INT_MASK_RST
             && stat_reg == INT_STATUS_RST)
      else $error("dead coin cell left registers set");
   a_vsel_follow: assert property (
         charger_voltage_select == ctl_reg[COIN_VSEL_LSB +: COIN_VSEL_W])
      else $error("voltage select differs from control register");

   c_power_up:  cover property (state_reg == PTC_OFF ##1 state_reg == PTC_ON);
   c_coin_in:   cover property (state_reg == PTC_ON ##1 state_reg == PTC_COIN);
   c_int_fire:  cover property ($fell(interrupt_out_n));
   c_therm_off: cover property (state_reg == PTC_ON && sd_db ##1 state_reg == PTC_OFF);
   c_coin_nak:  cover property (reg_rsp.nak);

endmodule : ptc_ctrl

// File: ptc_host_model.sv
`timescale 1ns/1ps
module ptc_host_model import ptc_pkg::*; (
   input  wire logic         clk_sys,
   output ptc_reg_req_t      reg_req,
   input  wire ptc_reg_rsp_t reg_rsp,
   input  wire logic         host_reset_out,
   input  wire logic         host_reset_out_oe,
   output logic              host_reset_n
);
   // Open-drain reset line, pulled up whenever the device lets go
   assign host_reset_n = host_reset_out_oe ? host_reset_out : 1'b1;

   initial reg_req = '0;

   // One byte access; idle fields are inverted so stale values never look valid
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic nk);
      @(posedge clk_sys);
      reg_req <= '{req: 1'b1, wr: wr, addr: a, wdata: d};
      @(posedge clk_sys);
      reg_req <= '{req: 1'b0, wr: ~wr, addr: ~a, wdata: ~d};
      @(posedge clk_sys);
      nk = reg_rsp.nak;
      q  = (reg_rsp.ack | reg_rsp.nak) ? reg_rsp.rdata : 8'hxx;
   endtask : access
endmodule : ptc_host_model

// File: test_pmic_power_state_thermal_coin_ctrl.sv
`timescale 1ns/1ps
module test_pmic_power_state_thermal_coin_ctrl;
   import ptc_pkg::*;
   // Short debounce counts keep the run brief
   localparam int SD_N  = 8;
   localparam int WN_N  = 4;
   localparam int LIMIT = 3000;

   logic         clk_sys, srst, ce, host_reset_n, host_reset_out, host_reset_out_oe;
   logic         interrupt_out_n, charger_on, charger_fixed_current, other_regulators_en;
   logic         core_digital_supply_en, backup_domain_supply_en;
   logic [2:0]   charger_voltage_select;
   ptc_state_t   power_state;
   ptc_cmp_t     cmp;
   ptc_reg_req_t reg_req;
   ptc_reg_rsp_t reg_rsp;
   int           err_total, check_count, cyc;

   ptc_ctrl #(.SD_DB_CYCLES(SD_N), .WARN_DB_CYCLES(WN_N)) u_ptc_ctrl (
      .clk_sys(clk_sys), .srst(srst), .ce(ce), .cmp_in(cmp), .reg_req(reg_req),
      .reg_rsp(reg_rsp), .host_reset_out(host_reset_out),
      .host_reset_out_oe(host_reset_out_oe), .interrupt_out_n(interrupt_out_n),
      .charger_on(charger_on), .charger_fixed_current(charger_fixed_current),
      .charger_voltage_select(charger_voltage_select),
      .core_digital_supply_en(core_digital_supply_en),
      .backup_domain_supply_en(backup_domain_supply_en),
      .other_regulators_en(other_regulators_en), .power_state(power_state));

   ptc_host_model u_ptc_host_model (
      .clk_sys(clk_sys), .reg_req(reg_req), .reg_rsp(reg_rsp),
      .host_reset_out(host_reset_out), .host_reset_out_oe(host_reset_out_oe),
      .host_reset_n(host_reset_n));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic       nk;
      u_ptc_host_model.access(1'b1, a, d, q, nk);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic nk_exp);
      logic [7:0] q;
      logic       nk;
      u_ptc_host_model.access(1'b0, a, 8'h00, q, nk);
      check(q, exp);
      check({7'h00, nk}, {7'h00, nk_exp});
   endtask : rd_chk

   // Bounded polls; the compare afterwards catches a transition that never came
   task automatic wait_state(input ptc_state_t s);
      for (int i = 0; i < 40 && power_state !== s; i++) @(posedge clk_sys);
      check(8'(power_state), 8'(s));
   endtask : wait_state

   task automatic wait_int(input logic v);
      for (int i = 0; i < 40 && interrupt_out_n !== v; i++) @(posedge clk_sys);
      check({7'h00, interrupt_out_n}, {7'h00, v});
   endtask : wait_int

   task automatic t_reset();
      check(8'(power_state), 8'(PTC_OFF));
      check({7'h00, host_reset_n}, 8'h00);
      check({5'h00, charger_on, other_regulators_en, interrupt_out_n}, 8'h01);
      check({6'h00, core_digital_supply_en, backup_domain_supply_en}, 8'h03);
      check({5'h00, charger_voltage_select}, 8'h00);
      rd_chk(ADDR_COIN_CTL, 8'h00, 1'b0);
      rd_chk(ADDR_INT_MASK, 8'h3f, 1'b0);
      rd_chk(ADDR_INT_STATUS, 8'h00, 1'b0);
      rd_chk(8'h20, 8'h00, 1'b0);
      $display("test reset done");
   endtask : t_reset

   // Turn-on with the input low must land in coin-cell and stay there
   task automatic t_coin();
      @(posedge clk_sys);
      cmp.pwr_on   <= 1'b1;
      cmp.uv_below <= 1'b1;
      wait_state(PTC_COIN);
      repeat (5) @(posedge clk_sys);
      check(8'(power_state), 8'(PTC_COIN));
      rd_chk(ADDR_COIN_CTL, 8'h00, 1'b1);
      check({7'h00, host_reset_n}, 8'h00);
      cmp.uv_below <= 1'b0;
      wait_state(PTC_OFF);
      wait_state(PTC_ON);
      check({6'h00, host_reset_n, other_regulators_en}, 8'h03);
      $display("test coin done");
   endtask : t_coin

   task automatic t_charger();
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_COIN_CTL, 8'hf8 | 8'(c));
         rd_chk(ADDR_COIN_CTL, 8'h08 | 8'(c), 1'b0);
         check({3'h0, charger_on, charger_fixed_current, charger_voltage_select},
               8'h18 | 8'(c));
      end
      // A write while the enable is low must not land
      ce <= 1'b0;
      wr(ADDR_COIN_CTL, 8'h00);
      ce <= 1'b1;
      rd_chk(ADDR_COIN_CTL, 8'h0f, 1'b0);
      wr(ADDR_COIN_CTL, 8'h07);
      check({3'h0, charger_on, charger_fixed_current, charger_voltage_select}, 8'h07);
      wr(ADDR_COIN_CTL, 8'h0b);
      cmp.uv_below <= 1'b1;
      wait_state(PTC_COIN);
      check({7'h00, charger_on}, 8'h00);
      cmp.uv_below <= 1'b0;
      wait_state(PTC_OFF);
      check({7'h00, charger_on}, 8'h00);
      wait_state(PTC_ON);
      $display("test charger done");
   endtask : t_charger

   // Rising crossings one at a time, then all four falling together
   task automatic t_thermal();
      wr(ADDR_INT_MASK, 8'h00);
      for (int i = 0; i < N_WARN; i++) begin
         cmp.warn[i] <= 1'b1;
         wait_int(1'b0);
         rd_chk(ADDR_INT_STATUS, 8'h04 << i, 1'b0);
         wr(ADDR_INT_STATUS, 8'h04 << i);
         wait_int(1'b1);
      end
      rd_chk(ADDR_INT_SENSE, THERM_FIELD, 1'b0);
      cmp.warn <= '0;
      wait_int(1'b0);
      rd_chk(ADDR_INT_STATUS, THERM_FIELD, 1'b0);
      rd_chk(ADDR_INT_SENSE, 8'h00, 1'b0);
      wr(ADDR_INT_MASK, 8'h3f);
      wait_int(1'b1);
      wr(ADDR_INT_MASK, 8'h00);
      wait_int(1'b0);
      $display("test thermal done");
   endtask : t_thermal

   // Status stays pending so the interrupt gating by state shows
   task automatic t_shutdown();
      cmp.sd_hot <= 1'b1;
      repeat (SD_N - 3) @(posedge clk_sys);
      cmp.sd_hot <= 1'b0;
      repeat (SD_N + 4) @(posedge clk_sys);
      check(8'(power_state), 8'(PTC_ON));
      cmp.sd_hot <= 1'b1;
      wait_state(PTC_OFF);
      check({7'h00, interrupt_out_n}, 8'h01);
      cmp.sd_hot <= 1'b0;
      repeat (SD_N + 6) @(posedge clk_sys); // Filter drained, only the lock holds OFF
      check(8'(power_state), 8'(PTC_OFF));
      cmp.sd_release <= 1'b1;
      wait_state(PTC_ON);
      cmp.sd_release <= 1'b0;
      wait_int(1'b0);
      wr(ADDR_INT_STATUS, THERM_FIELD);
      cmp.pwr_on <= 1'b0;
      wait_state(PTC_OFF);
      $display("test shutdown done");
   endtask : t_shutdown

   task automatic t_exhaust();
      wr(ADDR_COIN_CTL, 8'h0d);
      wr(ADDR_INT_MASK, 8'h15);
      cmp.coin_exhausted <= 1'b1;
      repeat (4) @(posedge clk_sys);
      cmp.coin_exhausted <= 1'b0;
      rd_chk(ADDR_COIN_CTL, 8'h00, 1'b0);
      rd_chk(ADDR_INT_MASK, 8'h3f, 1'b0);
      $display("test exhaust done");
   endtask : t_exhaust

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      srst        = 1'b1;
      ce          = 1'b1;
      cmp         = '0;
      cyc         = 0;
      err_total   = 0;
      check_count = 0;
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_coin();
      t_charger();
      t_thermal();
      t_shutdown();
      t_exhaust();
      complete_run();
   end
endmodule : test_pmic_power_state_thermal_coin_ctrl
